/* File: hdl/smh_consts.svh */
`ifndef SMH_CONSTS_SVH
`define SMH_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SMH_IER_ADDR 8'h01
`define SMH_MCTL_ADDR 8'h04
`define SMH_MSTAT_ADDR 8'h06
`define SMH_EVT_ADDR 8'h08
`define SMH_MASK_ADDR 8'h09
`define SMH_CFG_ADDR 8'h0A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMH_IER_MODEM_BIT 3
`define SMH_MCTL_RTS_BIT 1
`define SMH_MCTL_LOOP_BIT 4
`define SMH_CFG_DRIVE_BIT 0
`define SMH_CFG_STRAP_BIT 1
`define SMH_LINE_DCD 3
`define SMH_LINE_RI 2
`define SMH_LINE_DSR 1
`define SMH_LINE_CTS 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMH_MCTL_RST 5'h00
`define SMH_IER_RST 4'h0
`define SMH_DELTA_RST 4'h0
`define SMH_EVT_RST 4'h0
`define SMH_MASK_RST 4'hF
`define SMH_DRIVE_RST 1'h0
`define SMH_STRAP_RST 1'h0
`define SMH_RDATA_RST 8'h00

`endif

/* File: hdl/smh_pkg.sv */
`default_nettype none

package smh_pkg;

   // ----------------------------------------
   // Strap phase after reset
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      SMH_ST_INIT = 3'h1,
      SMH_ST_SAMPLE = 3'h2,
      SMH_ST_RUN = 3'h4
   } smh_phase_t;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } smh_bus_req_t;

   // Bit order matches the delta and event layout
   typedef struct packed
   {
      logic carrier_detect_n;
      logic ring_indicator_n;
      logic set_ready_n;
      logic clear_to_send_n;
   } smh_modem_in_t;

   // ----------------------------------------
   // Module state
   // ----------------------------------------
   typedef struct packed
   {
      logic valid;
      logic [3:0] prev_n;
      logic [3:0] lvl;
      logic [3:0] rise;
      logic [3:0] chg;
   } smh_sense_t;

   typedef struct packed
   {
      smh_phase_t phase;
      logic [4:0] mctl;
      logic [3:0] ier;
      logic [3:0] delta;
      logic [3:0] evt;
      logic [3:0] mask;
      logic drive_en;
      logic strap;
      logic [7:0] rdata;
   } smh_port_t;

endpackage : smh_pkg

`default_nettype wire

/* File: hdl/smh_pin_sense.sv */
`timescale 1ns/1ps
`default_nettype none

module smh_pin_sense
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire smh_pkg::smh_modem_in_t pins_i,
   output logic [3:0] lvl_o,
   output logic [3:0] rise_o,
   output logic [3:0] chg_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   smh_pkg::smh_sense_t s_r;
   smh_pkg::smh_sense_t s_nxt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // No edge is reported in the first cycle after reset, since
   // the previous pin level is not yet known
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.valid = 1'b1;
      s_nxt.prev_n = pins_i;
      s_nxt.lvl = ~pins_i;
      if (s_r.valid)
      begin
         s_nxt.rise = ~s_r.prev_n & pins_i;
         s_nxt.chg = s_r.prev_n ^ pins_i;
      end
      else
      begin
         s_nxt.rise = 4'h0;
         s_nxt.chg = 4'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign lvl_o = s_r.lvl;
   assign rise_o = s_r.rise;
   assign chg_o = s_r.chg;

endmodule : smh_pin_sense

`default_nettype wire

/* File: hdl/smh_port.sv */
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "smh_consts.svh"

module smh_port
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire smh_pkg::smh_bus_req_t bus_i,
   output logic [7:0] rdata_o,
   input wire smh_pkg::smh_modem_in_t modem_i,
   input wire logic request_to_send_n_i,
   output logic request_to_send_n_o,
   output logic request_to_send_n_oe_o,
   output logic config_base_strap_o,
   output logic irq_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Set wins over clear, so an edge in the clearing cycle is kept
   function automatic logic [3:0] set_clr(input logic [3:0] old,
                                          input logic [3:0] set,
                                          input logic [3:0] clr);
      set_clr = (old & ~clr) | set;
   endfunction : set_clr

   function automatic logic hit(input smh_pkg::smh_bus_req_t b,
                                input logic [7:0] a);
      hit = (b.addr == a);
   endfunction : hit

   // ----------------------------------------
   // State
   // ----------------------------------------
   localparam smh_pkg::smh_port_t RST = '{
      phase: smh_pkg::SMH_ST_INIT,
      mctl: `SMH_MCTL_RST,
      ier: `SMH_IER_RST,
      delta: `SMH_DELTA_RST,
      evt: `SMH_EVT_RST,
      mask: `SMH_MASK_RST,
      drive_en: `SMH_DRIVE_RST,
      strap: `SMH_STRAP_RST,
      rdata: `SMH_RDATA_RST
   };

   smh_pkg::smh_port_t s_r;
   smh_pkg::smh_port_t s_nxt;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic [3:0] chg;
   logic [3:0] delta_clr;
   logic [3:0] evt_set;
   logic [3:0] evt_clr;
   logic loop_mode;

   // ----------------------------------------
   // Pin sensing
   // ----------------------------------------
   smh_pin_sense u_sense
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pins_i(modem_i),
      .lvl_o(lvl),
      .rise_o(rise),
      .chg_o(chg)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rdata = 8'h00;
      delta_clr = 4'h0;
      evt_clr = 4'h0;
      evt_set = 4'h0;

      // Strap is caught while the pin is still undriven
      case (s_r.phase)
         smh_pkg::SMH_ST_INIT:
         begin
            s_nxt.phase = smh_pkg::SMH_ST_SAMPLE;
         end
         smh_pkg::SMH_ST_SAMPLE:
         begin
            s_nxt.strap = request_to_send_n_i;
            s_nxt.phase = smh_pkg::SMH_ST_RUN;
         end
         smh_pkg::SMH_ST_RUN:
         begin
            s_nxt.phase = smh_pkg::SMH_ST_RUN;
         end
         default:
         begin
            s_nxt.phase = smh_pkg::SMH_ST_INIT;
         end
      endcase

      // Register reads
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            `SMH_IER_ADDR:
            begin
               s_nxt.rdata = {4'h0, s_r.ier};
            end
            `SMH_MCTL_ADDR:
            begin
               s_nxt.rdata = {3'h0, s_r.mctl};
            end
            `SMH_MSTAT_ADDR:
            begin
               // Levels in bits 7..4, change bits in 3..0
               s_nxt.rdata = {lvl, s_r.delta};
               delta_clr = 4'hF;
            end
            `SMH_EVT_ADDR:
            begin
               s_nxt.rdata = {4'h0, s_r.evt};
            end
            `SMH_MASK_ADDR:
            begin
               s_nxt.rdata = {4'h0, s_r.mask};
            end
            `SMH_CFG_ADDR:
            begin
               s_nxt.rdata = {6'h00, s_r.strap, s_r.drive_en};
            end
            default:
            begin
               s_nxt.rdata = 8'h00;
            end
         endcase
      end

      // Register writes
      if (bus_i.wr)
      begin
         case (bus_i.addr)
            `SMH_IER_ADDR:
            begin
               s_nxt.ier = bus_i.wdata[3:0];
            end
            `SMH_MCTL_ADDR:
            begin
               s_nxt.mctl = bus_i.wdata[4:0];
            end
            `SMH_EVT_ADDR:
            begin
               evt_clr = bus_i.wdata[3:0];
            end
            `SMH_MASK_ADDR:
            begin
               s_nxt.mask = bus_i.wdata[3:0];
            end
            `SMH_CFG_ADDR:
            begin
               s_nxt.drive_en = bus_i.wdata[`SMH_CFG_DRIVE_BIT];
            end
            default:
            begin
               s_nxt.drive_en = s_r.drive_en;
            end
         endcase
      end

      // Change bits latch pin low to high edges
      s_nxt.delta = set_clr(s_r.delta, rise, delta_clr);

      // Any state change is an event while modem interrupts are on
      if (s_r.ier[`SMH_IER_MODEM_BIT])
      begin
         evt_set = chg;
      end
      s_nxt.evt = set_clr(s_r.evt, evt_set, evt_clr);
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         s_r <= RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign loop_mode = s_r.mctl[`SMH_MCTL_LOOP_BIT];
   // Loop mode keeps the modem from seeing test traffic handshakes
   assign request_to_send_n_o = ~(s_r.mctl[`SMH_MCTL_RTS_BIT] & ~loop_mode);
   // Drive only after the strap is caught and software allows it
   assign request_to_send_n_oe_o = s_r.drive_en
                                   & (s_r.phase == smh_pkg::SMH_ST_RUN);
   assign config_base_strap_o = s_r.strap;
   assign irq_o = |(s_r.evt & s_r.mask);
   assign rdata_o = s_r.rdata;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (!resetn_i);

   chk_dcd_level: assert property (
      bus_i.rd && hit(bus_i, `SMH_MSTAT_ADDR)
      |=> rdata_o[7] == $past(lvl[`SMH_LINE_DCD]))
      else $error("carrier detect level wrong in status read");

   chk_dsr_level: assert property (
      bus_i.rd && hit(bus_i, `SMH_MSTAT_ADDR)
      |=> rdata_o[5] == $past(lvl[`SMH_LINE_DSR]))
      else $error("data set ready level wrong in status read");

   chk_cts_level: assert property (
      bus_i.rd && hit(bus_i, `SMH_MSTAT_ADDR) && s_r.delta[0]
      |=> rdata_o[4] == $past(lvl[`SMH_LINE_CTS]) && rdata_o[0])
      else $error("clear to send bits wrong in status read");

   chk_ri_level: assert property (
      bus_i.rd && hit(bus_i, `SMH_MSTAT_ADDR) && s_r.delta[2]
      |=> rdata_o[6] == $past(lvl[`SMH_LINE_RI]) && rdata_o[2])
      else $error("ring indicator bits wrong in status read");

   chk_dcd_delta: assert property (
      rise[`SMH_LINE_DCD] |=> s_r.delta[`SMH_LINE_DCD])
      else $error("carrier detect rise not latched");

   chk_dsr_delta: assert property (
      rise[`SMH_LINE_DSR] |=> s_r.delta[`SMH_LINE_DSR])
      else $error("data set ready rise not latched");

   chk_irq_dcd: assert property (
      chg[`SMH_LINE_DCD] && s_r.ier[`SMH_IER_MODEM_BIT] && s_r.mask[`SMH_LINE_DCD]
      |=> irq_o)
      else $error("carrier detect change gave no interrupt");

   chk_irq_dsr: assert property (
      chg[`SMH_LINE_DSR] && s_r.ier[`SMH_IER_MODEM_BIT] && s_r.mask[`SMH_LINE_DSR]
      |=> irq_o)
      else $error("data set ready change gave no interrupt");

   chk_rts_follow: assert property (
      bus_i.wr && hit(bus_i, `SMH_MCTL_ADDR)
      |=> request_to_send_n_o == !($past(bus_i.wdata[`SMH_MCTL_RTS_BIT])
                                   && !$past(bus_i.wdata[`SMH_MCTL_LOOP_BIT])))
      else $error("request to send does not follow control write");

   chk_rts_reset: assert property (
      $rose(resetn_i) |-> request_to_send_n_o && !request_to_send_n_oe_o)
      else $error("request to send active after reset");

   chk_rts_loop: assert property (
      loop_mode |-> request_to_send_n_o)
      else $error("request to send active in loop mode");

   chk_oe_unconfig: assert property (
      !s_r.drive_en |-> !request_to_send_n_oe_o)
      else $error("request to send driven before configured");

   chk_strap_catch: assert property (
      s_r.phase == smh_pkg::SMH_ST_SAMPLE
      |=> config_base_strap_o == $past(request_to_send_n_i))
      else $error("strap not caught from pin");

   chk_msr_clear: assert property (
      bus_i.rd && hit(bus_i, `SMH_MSTAT_ADDR) && rise == 4'h0
      |=> s_r.delta == 4'h0)
      else $error("status read left change bits set");

   chk_cts_delta: assert property (
      rise[`SMH_LINE_CTS] |=> s_r.delta[`SMH_LINE_CTS])
      else $error("clear to send rise not latched");

   chk_ri_delta: assert property (
      rise[`SMH_LINE_RI] |=> s_r.delta[`SMH_LINE_RI])
      else $error("ring indicator rise not latched");

   chk_dcd_quiet: assert property (
      !s_r.delta[`SMH_LINE_DCD] && !rise[`SMH_LINE_DCD] |=> !s_r.delta[`SMH_LINE_DCD])
      else $error("carrier detect change bit set without rise");

   chk_dsr_quiet: assert property (
      !s_r.delta[`SMH_LINE_DSR] && !rise[`SMH_LINE_DSR] |=> !s_r.delta[`SMH_LINE_DSR])
      else $error("data set ready change bit set without rise");

   chk_evt_gate: assert property (
      !s_r.ier[`SMH_IER_MODEM_BIT] && s_r.evt == 4'h0 |=> s_r.evt == 4'h0)
      else $error("event latched while modem interrupts off");

   chk_evt_sticky: assert property (
      s_r.evt[`SMH_LINE_DCD]
      && !(bus_i.wr && hit(bus_i, `SMH_EVT_ADDR) && bus_i.wdata[`SMH_LINE_DCD])
      |=> s_r.evt[`SMH_LINE_DCD])
      else $error("carrier detect event lost before clear");

   chk_irq_quiet: assert property (
      s_r.evt == 4'h0 |-> !irq_o)
      else $error("interrupt without pending event");

   chk_rts_hold: assert property (
      !(bus_i.wr && hit(bus_i, `SMH_MCTL_ADDR)) |=> $stable(request_to_send_n_o))
      else $error("request to send moved without control write");

   chk_strap_hold: assert property (
      s_r.phase == smh_pkg::SMH_ST_RUN |=> $stable(config_base_strap_o))
      else $error("strap changed after capture");

   chk_oe_drive: assert property (
      bus_i.wr && hit(bus_i, `SMH_CFG_ADDR) && bus_i.wdata[`SMH_CFG_DRIVE_BIT]
      && s_r.phase == smh_pkg::SMH_ST_RUN
      |=> request_to_send_n_oe_o)
      else $error("request to send not driven after enable");

endmodule : smh_port

`default_nettype wire

/* File: test/smh_modem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module smh_modem_model
(
   input wire logic clk_i,
   input wire logic [3:0] want_n_i,
   input wire logic strap_pull_i,
   input wire logic rts_n_i,
   input wire logic rts_oe_i,
   output smh_pkg::smh_modem_in_t pins_o,
   output logic rts_pin_o
);
   // ----------------------------------------
   // Modem lines
   // ----------------------------------------
   // Lines move just after an edge, so the port never sees a half-cycle glitch
   always_ff @(posedge clk_i)
   begin
      pins_o <= smh_pkg::smh_modem_in_t'(want_n_i);
   end

   // ----------------------------------------
   // Request-to-send pin
   // ----------------------------------------
   // A released pin falls back to the board strap resistor
   assign rts_pin_o = rts_oe_i ? rts_n_i : strap_pull_i;
endmodule : smh_modem_model

`default_nettype wire

/* File: test/tb_smh_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smh_consts.svh"

module tb_smh_port;
   logic clk_i;
   logic resetn_i;
   smh_pkg::smh_bus_req_t bus_i;
   logic [7:0] rdata_o;
   smh_pkg::smh_modem_in_t modem_i;
   logic [3:0] want_n;
   logic rts_pin;
   logic strap_pull;
   logic rts_n_o;
   logic rts_oe_o;
   logic strap_o;
   logic irq_o;
   int mismatches;
   int checks_done;
   int cycles = 0;

   smh_port u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .modem_i(modem_i), .request_to_send_n_i(rts_pin), .request_to_send_n_o(rts_n_o),
      .request_to_send_n_oe_o(rts_oe_o), .config_base_strap_o(strap_o), .irq_o(irq_o));

   smh_modem_model u_modem (.clk_i(clk_i), .want_n_i(want_n), .strap_pull_i(strap_pull),
      .rts_n_i(rts_n_o), .rts_oe_i(rts_oe_o), .pins_o(modem_i), .rts_pin_o(rts_pin));

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Whole run is well under a thousand cycles; the ceiling leaves ample room
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches = mismatches + 1;
         end_sim();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_i <= '0;
      #1;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_i <= '0;
      #1;
      check(rdata_o, exp);
   endtask : rd

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      mismatches = 0;
      checks_done = 0;
      strap_pull = 1'b1;
      resetn_i = 1'b0;
      bus_i = '0;
      want_n = 4'hF;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      wait_cyc(4);
      check({6'h00, rts_oe_o, rts_n_o}, 8'h01);
      check({7'h00, strap_o}, 8'h01);
      rd(`SMH_CFG_ADDR, 8'h02);
      rd(`SMH_MSTAT_ADDR, 8'h00);
      rd(`SMH_MASK_ADDR, 8'h0F);
      rd(8'h30, 8'h00);
      // Gate closed: a change must not leave an event behind
      want_n = 4'h7;
      wait_cyc(6);
      rd(`SMH_EVT_ADDR, 8'h00);
      check({7'h00, irq_o}, 8'h00);
      rd(`SMH_MSTAT_ADDR, 8'h80);
      want_n = 4'hF;
      wait_cyc(6);
      rd(`SMH_MSTAT_ADDR, 8'h08);
      wr(`SMH_IER_ADDR, 8'h08);
      rd(`SMH_IER_ADDR, 8'h08);
      for (int i = 0; i < 4; i++)
      begin
         want_n = 4'hF ^ (4'h1 << i);
         wait_cyc(6);
         rd(`SMH_MSTAT_ADDR, 8'h10 << i);
         rd(`SMH_EVT_ADDR, 8'h01 << i);
         check({7'h00, irq_o}, 8'h01);
         wr(`SMH_EVT_ADDR, 8'h01 << i);
         check({7'h00, irq_o}, 8'h00);
         want_n = 4'hF;
         wait_cyc(6);
         rd(`SMH_MSTAT_ADDR, 8'h01 << i);
         rd(`SMH_MSTAT_ADDR, 8'h00);
         rd(`SMH_EVT_ADDR, 8'h01 << i);
         wr(`SMH_EVT_ADDR, 8'h0F);
      end
      // Masked event stays pending without interrupt
      wr(`SMH_MASK_ADDR, 8'h00);
      rd(`SMH_MASK_ADDR, 8'h00);
      wr(8'h30, 8'hFF);
      want_n = 4'hD;
      wait_cyc(6);
      check({7'h00, irq_o}, 8'h00);
      wr(`SMH_MASK_ADDR, 8'h0F);
      check({7'h00, irq_o}, 8'h01);
      // Request-to-send pin
      wr(`SMH_MCTL_ADDR, 8'h02);
      check({6'h00, rts_oe_o, rts_pin}, 8'h01);
      wr(`SMH_CFG_ADDR, 8'h01);
      check({6'h00, rts_oe_o, rts_pin}, 8'h02);
      wr(`SMH_MCTL_ADDR, 8'h12);
      check({7'h00, rts_n_o}, 8'h01);
      wr(`SMH_MCTL_ADDR, 8'h02);
      check({7'h00, rts_n_o}, 8'h00);
      wr(`SMH_MCTL_ADDR, 8'h00);
      check({7'h00, rts_n_o}, 8'h01);
      wr(`SMH_MCTL_ADDR, 8'h02);
      // Reset in mid-run must let go of the pin at once
      rd(`SMH_MCTL_ADDR, 8'h02);
      @(posedge clk_i);
      resetn_i <= 1'b0;
      // Board strap now pulls low, so the recaptured strap must follow it
      strap_pull <= 1'b0;
      wait_cyc(2);
      check({6'h00, rts_oe_o, rts_n_o}, 8'h01);
      check({7'h00, irq_o}, 8'h00);
      @(posedge clk_i);
      resetn_i <= 1'b1;
      wait_cyc(4);
      check({7'h00, strap_o}, 8'h00);
      rd(`SMH_CFG_ADDR, 8'h00);
      rd(`SMH_MCTL_ADDR, 8'h00);
      end_sim();
   end
endmodule : tb_smh_port

`default_nettype wire
